// ---- hdl/acr_cal_regs.v ----
// channel 2/3 calibration and input configuration register bank
// ==========================================================
// Summary of operation
// - ch2 gain bits 23:8 in high register
// - ch2 gain bits 7:0 upper byte, low zero
// - gain word unsigned, zero to almost two
// - ch2 gain resets to 8000h and 0000h
// - ch3 gain resets to 8000h and 0000h
// - ch3 gain split high/upper byte, low zero
// - ch3 offset split likewise, resets zero
// - ch3 two-bit input selector, reset pins
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "acr_regs.vh"

module acr_cal_regs (
  input  wire        sys_clk,          // system clock, 25 MHz
  input  wire        nrst,             // synchronous reset, active low
  input  wire [7:0]  avs_address,      // byte address
  input  wire        avs_read,         // read request
  input  wire        avs_write,        // write request
  input  wire [31:0] avs_writedata,    // write data
  input  wire [3:0]  avs_byteenable,   // byte enables
  output reg  [31:0] avs_readdata,     // read data
  output wire        avs_waitrequest,  // stall
  output wire [23:0] ch2GainWord,      // ch2 gain correction word
  output wire [23:0] ch3GainWord,      // ch3 gain correction word
  output wire [23:0] ch3OffsetWord,    // ch3 offset correction word
  output wire [1:0]  ch3InputSelect,   // ch3 selector
  output wire        ch3PinsOn,        // ch3 pins routed
  output wire        ch3InputsShort,   // ch3 inputs shorted
  output wire        ch3TestPos,       // ch3 positive test signal
  output wire        ch3TestNeg        // ch3 negative test signal
);

  // ==========================================================
  // bus handshake: one wait cycle, answer on the second
  reg         ack;
  wire        req;
  wire [5:0]  idx;
  wire        wordAligned;
  wire        loEn;
  wire        hiEn;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign idx             = avs_address[7:2];
  assign wordAligned     = (avs_address[1:0] == 2'h0);
  assign loEn            = avs_byteenable[0];
  assign hiEn            = avs_byteenable[1];

  always @(posedge sys_clk) begin
    if (!nrst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ==========================================================
  // write decode; the register takes the write at the ack edge
  wire        wrFire;
  reg  [15:0] mergeData;
  reg  [15:0] curVal;
  wire        wrCh2GainHigh;
  wire        wrCh2GainLow;
  wire        wrCfg;
  wire        wrCh3OfsHigh;
  wire        wrCh3OfsLow;
  wire        wrCh3GainHigh;
  wire        wrCh3GainLow;

  assign wrFire = avs_write & ack & wordAligned;

  assign wrCh2GainHigh = wrFire & (idx == `ACR_IDX_CH2_GAIN_HIGH);
  assign wrCh2GainLow  = wrFire & (idx == `ACR_IDX_CH2_GAIN_LOW);
  assign wrCfg         = wrFire & (idx == `ACR_IDX_CH3_INPUT_CONFIG);
  assign wrCh3OfsHigh  = wrFire & (idx == `ACR_IDX_CH3_OFS_HIGH);
  assign wrCh3OfsLow   = wrFire & (idx == `ACR_IDX_CH3_OFS_LOW);
  assign wrCh3GainHigh = wrFire & (idx == `ACR_IDX_CH3_GAIN_HIGH);
  assign wrCh3GainLow  = wrFire & (idx == `ACR_IDX_CH3_GAIN_LOW);

  // lanes with byteenable low keep the stored value
  always @* begin
    mergeData[7:0]  = loEn ? avs_writedata[7:0]  : curVal[7:0];
    mergeData[15:8] = hiEn ? avs_writedata[15:8] : curVal[15:8];
  end

  // ==========================================================
  // calibration words
  wire [15:0] ch2GainHigh;
  wire [7:0]  ch2GainLow;
  wire [15:0] ch3OfsHigh;
  wire [7:0]  ch3OfsLow;
  wire [15:0] ch3GainHigh;
  wire [7:0]  ch3GainLow;

  // unsigned gain, 800000h is unity, full code just under two
  acr_cal_word #(
    .HIGH_RESET (`ACR_RST_GAIN_HIGH)
  ) u_ch2Gain (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .wrHigh   (wrCh2GainHigh),
    .wrLow    (wrCh2GainLow),
    .wrData   (mergeData),
    .wordHigh (ch2GainHigh),
    .wordLow  (ch2GainLow),
    .calWord  (ch2GainWord)
  );

  acr_cal_word #(
    .HIGH_RESET (`ACR_RST_ZERO16)
  ) u_ch3Ofs (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .wrHigh   (wrCh3OfsHigh),
    .wrLow    (wrCh3OfsLow),
    .wrData   (mergeData),
    .wordHigh (ch3OfsHigh),
    .wordLow  (ch3OfsLow),
    .calWord  (ch3OffsetWord)
  );

  acr_cal_word #(
    .HIGH_RESET (`ACR_RST_GAIN_HIGH)
  ) u_ch3Gain (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .wrHigh   (wrCh3GainHigh),
    .wrLow    (wrCh3GainLow),
    .wrData   (mergeData),
    .wordHigh (ch3GainHigh),
    .wordLow  (ch3GainLow),
    .calWord  (ch3GainWord)
  );

  // ==========================================================
  // channel 3 configuration
  // bits 15:6 and 2 are writable reserved and kept as written;
  // bits 5:3 are read-only zero
  reg  [9:0] cfgHigh;
  reg        cfgBit2;
  reg  [1:0] cfgSel;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      cfgHigh <= 10'h000;
      cfgBit2 <= 1'b0;
      cfgSel  <= `ACR_RST_SEL;
    end else if (wrCfg) begin
      cfgHigh <= mergeData[`ACR_CFG_HIGH_MSB:`ACR_CFG_HIGH_LSB];
      cfgBit2 <= mergeData[`ACR_CFG_BIT2];
      cfgSel  <= mergeData[`ACR_SEL_MSB:0];
    end
  end

  assign ch3InputSelect = cfgSel;

  acr_sel_decode u_ch3Sel (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .sel         (cfgSel),
    .pinsOn      (ch3PinsOn),
    .inputsShort (ch3InputsShort),
    .testPos     (ch3TestPos),
    .testNeg     (ch3TestNeg)
  );

  // ==========================================================
  // read mux; also supplies the current value for lane merging
  reg mapped;

  always @* begin
    mapped = 1'b1;
    case (idx)
      `ACR_IDX_CH2_GAIN_HIGH: curVal = ch2GainHigh;
      `ACR_IDX_CH2_GAIN_LOW:  curVal = {ch2GainLow, `ACR_RST_BYTE};
      `ACR_IDX_CH3_INPUT_CONFIG:       curVal = {cfgHigh, 3'h0, cfgBit2, cfgSel};
      `ACR_IDX_CH3_OFS_HIGH:  curVal = ch3OfsHigh;
      `ACR_IDX_CH3_OFS_LOW:   curVal = {ch3OfsLow, `ACR_RST_BYTE};
      `ACR_IDX_CH3_GAIN_HIGH: curVal = ch3GainHigh;
      `ACR_IDX_CH3_GAIN_LOW:  curVal = {ch3GainLow, `ACR_RST_BYTE};
      default: begin
        curVal = `ACR_RST_ZERO16;
        mapped = 1'b0;
      end
    endcase
  end

  // read data is registered and valid at the ack edge
  always @(posedge sys_clk) begin
    if (!nrst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack) begin
      if (mapped & wordAligned) begin
        avs_readdata <= {16'h0000, curVal};
      end else begin
        avs_readdata <= `ACR_UNMAPPED_DATA;
      end
    end
  end

endmodule

// ---- hdl/acr_cal_word.v ----
// one 24-bit calibration word split over a high and a low register
`timescale 1ns/100ps
`include "acr_regs.vh"

module acr_cal_word #(
  parameter [15:0] HIGH_RESET = 16'h0000
) (
  input  wire        sys_clk,   // system clock
  input  wire        nrst,      // synchronous reset, active low
  input  wire        wrHigh,    // write strobe, high register
  input  wire        wrLow,     // write strobe, low register
  input  wire [15:0] wrData,    // write data
  output reg  [15:0] wordHigh,  // word bits 23:8
  output reg  [7:0]  wordLow,   // word bits 7:0
  output wire [23:0] calWord    // full calibration word
);

  // ==========================================================
  // storage
  always @(posedge sys_clk) begin
    if (!nrst) begin
      wordHigh <= HIGH_RESET;
      wordLow  <= `ACR_RST_BYTE;
    end else begin
      if (wrHigh) begin
        wordHigh <= wrData;
      end
      // lower byte of the low register is not stored
      if (wrLow) begin
        wordLow <= wrData[`ACR_LOW_FIELD_MSB:`ACR_LOW_FIELD_LSB];
      end
    end
  end

  assign calWord = {wordHigh, wordLow};

endmodule

// ---- hdl/acr_sel_decode.v ----
// decoder of the channel 3 input selector into routing enables
`timescale 1ns/100ps
`include "acr_regs.vh"

module acr_sel_decode (
  input  wire       sys_clk,      // system clock
  input  wire       nrst,         // synchronous reset, active low
  input  wire [1:0] sel,          // input selector
  output reg        pinsOn,       // positive and negative pins routed
  output reg        inputsShort,  // pins off, inputs shorted
  output reg        testPos,      // positive dc test signal
  output reg        testNeg       // negative dc test signal
);

  // ==========================================================
  // registered one-hot routing, so the mux never sees glitches
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pinsOn      <= 1'b1;
      inputsShort <= 1'b0;
      testPos     <= 1'b0;
      testNeg     <= 1'b0;
    end else begin
      pinsOn      <= (sel == `ACR_SEL_PINS);
      inputsShort <= (sel == `ACR_SEL_SHORTED);
      testPos     <= (sel == `ACR_SEL_TEST_POS);
      testNeg     <= (sel == `ACR_SEL_TEST_NEG);
    end
  end

endmodule

// ---- shared/acr_regs.vh ----
// register map constants for the channel calibration register bank
`ifndef ACR_REGS_VH
`define ACR_REGS_VH

// ==========================================================
// register indices (byte address = 4 * index)
`define ACR_IDX_CH2_GAIN_HIGH   6'h16
`define ACR_IDX_CH2_GAIN_LOW    6'h17
`define ACR_IDX_CH3_INPUT_CONFIG         6'h18
`define ACR_IDX_CH3_OFS_HIGH    6'h19
`define ACR_IDX_CH3_OFS_LOW     6'h1A
`define ACR_IDX_CH3_GAIN_HIGH   6'h1B
`define ACR_IDX_CH3_GAIN_LOW    6'h1C

// ==========================================================
// reset values
`define ACR_RST_GAIN_HIGH       16'h8000
`define ACR_RST_ZERO16          16'h0000
`define ACR_RST_BYTE            8'h00
`define ACR_RST_SEL             2'h0

// ==========================================================
// field positions
`define ACR_LOW_FIELD_MSB       15
`define ACR_LOW_FIELD_LSB       8
`define ACR_CFG_HIGH_MSB        15
`define ACR_CFG_HIGH_LSB        6
`define ACR_CFG_BIT2            2
`define ACR_SEL_MSB             1

// ==========================================================
// input selector codes
`define ACR_SEL_PINS            2'h0
`define ACR_SEL_SHORTED         2'h1
`define ACR_SEL_TEST_POS        2'h2
`define ACR_SEL_TEST_NEG        2'h3

// ==========================================================
// bus answer for an unmapped address
`define ACR_UNMAPPED_DATA       32'h00000000

`endif

// ---- tb/acr_cal_regs_checker.sv ----
// assertion checker for the calibration register bank
`timescale 1ns/100ps
module acr_cal_regs_checker (
  input wire        sys_clk,          // clock
  input wire        nrst,             // reset
  input wire [7:0]  avs_address,      // address
  input wire        avs_read,         // read
  input wire        avs_write,        // write
  input wire [31:0] avs_writedata,    // wdata
  input wire [3:0]  avs_byteenable,   // lanes
  input wire [31:0] avs_readdata,     // rdata
  input wire        avs_waitrequest,  // stall
  input wire [23:0] ch2GainWord,      // ch2 gain
  input wire [23:0] ch3GainWord,      // ch3 gain
  input wire [23:0] ch3OffsetWord,    // ch3 offset
  input wire [1:0]  ch3InputSelect,   // selector
  input wire        ch3PinsOn,        // pins
  input wire        ch3InputsShort,   // shorted
  input wire        ch3TestPos,       // test +
  input wire        ch3TestNeg        // test -
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire [5:0] idx    = avs_address[7:2];
  wire       wrDone = avs_write & ~avs_waitrequest & (avs_address[1:0] == 2'h0);
  wire       rdDone = avs_read & ~avs_waitrequest;
  wire       both   = avs_byteenable[1:0] == 2'h3;
  // ==========================================================
  // register contents
  property p_rstVal;
    $rose(nrst) |-> ch2GainWord == 24'h800000 && ch3GainWord == 24'h800000
      && ch3OffsetWord == 24'h000000 && ch3InputSelect == 2'h0;
  endproperty
  a_rstVal: assert property (p_rstVal) else $error("reset value wrong");
  property p_lowZero;
    rdDone && (idx == 6'h17 || idx == 6'h1A || idx == 6'h1C) |-> avs_readdata[7:0] == 8'h00;
  endproperty
  a_lowZero: assert property (p_lowZero) else $error("low byte not zero");
  property p_cfgZero;
    rdDone && idx == 6'h18 |-> avs_readdata[5:3] == 3'h0;
  endproperty
  a_cfgZero: assert property (p_cfgZero) else $error("cfg bits 5:3 set");
  property p_ch2High;
    wrDone && idx == 6'h16 && both |=> ch2GainWord[23:8] == $past(avs_writedata[15:0]);
  endproperty
  a_ch2High: assert property (p_ch2High) else $error("ch2 gain high");
  property p_ch2Low;
    wrDone && idx == 6'h17 && avs_byteenable[1] |=> ch2GainWord[7:0] == $past(avs_writedata[15:8]);
  endproperty
  a_ch2Low: assert property (p_ch2Low) else $error("ch2 gain low");
  property p_ch3Gain;
    wrDone && idx == 6'h1B && both |=> ch3GainWord[23:8] == $past(avs_writedata[15:0]);
  endproperty
  a_ch3Gain: assert property (p_ch3Gain) else $error("ch3 gain high");
  property p_sel;
    wrDone && idx == 6'h18 && avs_byteenable[0] |=> ch3InputSelect == $past(avs_writedata[1:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("selector not stored");
  // decode trails the selector by one cycle
  property p_route;
    1'b1 |=> {ch3TestNeg, ch3TestPos, ch3InputsShort, ch3PinsOn} == 4'h1 << $past(ch3InputSelect);
  endproperty
  a_route: assert property (p_route) else $error("routing decode wrong");
endmodule

bind acr_cal_regs acr_cal_regs_checker u_chk (.*);

// ---- tb/acr_tb.sv ----
// self-checking bench for the calibration register bank
`timescale 1ns/100ps
module tb;
  reg         sys_clk, nrst, avs_read, avs_write;
  reg  [7:0]  avs_address;
  reg  [31:0] avs_writedata, q;
  reg  [3:0]  avs_byteenable, be;
  reg  [15:0] d;
  reg  [15:0] mdl [0:6];
  wire [31:0] avs_readdata;
  wire [23:0] ch2GainWord, ch3GainWord, ch3OffsetWord;
  wire [1:0]  ch3InputSelect;
  wire        avs_waitrequest, ch3PinsOn, ch3InputsShort, ch3TestPos, ch3TestNeg;
  integer     n_errors, total_checks, seed, i, k;
  acr_cal_regs DUT (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input rd, input [7:0] a, input [15:0] wd, input [3:0] lanes);
    begin
      @(posedge sys_clk);
      avs_read <= rd;
      avs_write <= ~rd;
      avs_address <= a;
      avs_writedata <= {$random(seed), wd} & 32'hFFFFFFFF;
      avs_byteenable <= lanes;
      @(posedge sys_clk);
      // first edge of every request must stall; the wait itself is open-ended
      chk("waitrequest", 32'h1, {31'h0, avs_waitrequest});
      while (avs_waitrequest !== 1'b0) begin
        @(posedge sys_clk);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  function [7:0] adr(input integer r);
    adr = 8'h58 + {r[5:0], 2'h0};
  endfunction
  // what the register keeps after a write, unstored low bytes and read-only zero bits 5:3 dropped
  function [15:0] merge(input [15:0] o, input [15:0] w, input [3:0] l, input integer r);
    merge = {l[1] ? w[15:8] : o[15:8], l[0] ? w[7:0] : o[7:0]}
      & ((r == 1 || r == 4 || r == 6) ? 16'hFF00 : (r == 2) ? 16'hFFC7 : 16'hFFFF);
  endfunction
  task rdChk(input integer r);
    begin
      bus(1'b1, adr(r), 16'h0000, 4'hF);
      chk("register", {16'h0000, mdl[r]}, q);
    end
  endtask
  task allChk;
    begin
      repeat (2) @(posedge sys_clk);
      chk("ch2 gain", {8'h00, mdl[0], mdl[1][15:8]}, {8'h00, ch2GainWord});
      chk("ch3 offset", {8'h00, mdl[3], mdl[4][15:8]}, {8'h00, ch3OffsetWord});
      chk("ch3 gain", {8'h00, mdl[5], mdl[6][15:8]}, {8'h00, ch3GainWord});
      chk("route", 32'h1 << mdl[2][1:0],
          {28'h0, ch3TestNeg, ch3TestPos, ch3InputsShort, ch3PinsOn});
      chk("selector", {30'h0, mdl[2][1:0]}, {30'h0, ch3InputSelect});
      for (i = 0; i < 7; i = i + 1) rdChk(i);
    end
  endtask
  task rstModel;
    for (i = 0; i < 7; i = i + 1) mdl[i] = (i == 0 || i == 5) ? 16'h8000 : 16'h0000;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    {n_errors, total_checks, seed} = {32'h0, 32'h0, 32'hEDE70595};
    {nrst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = 0;
    rstModel;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    allChk;
    $display("test reset done");
    // full scale, then zero, then random traffic
    for (k = 0; k < 40; k = k + 1) begin
      i = (k < 14) ? k % 7 : {$random(seed)} % 7;
      d = (k < 7) ? 16'hFFFF : (k < 14) ? 16'h0000 : $random(seed);
      be = (k < 14) ? 4'hF : $random(seed);
      if (i == 2) d = d & 16'h0003;
      bus(1'b0, adr(i), d, be);
      mdl[i] = merge(mdl[i], d, be, i);
      if (k == 6 || k > 30) allChk;
    end
    allChk;
    $display("test traffic done");
    for (k = 0; k < 4; k = k + 1) begin
      bus(1'b0, adr(2), k[15:0], 4'h1);
      mdl[2] = merge(mdl[2], k[15:0], 4'h1, 2);
      allChk;
    end
    $display("test selector done");
    bus(1'b0, 8'h74, 16'hFFFF, 4'hF);
    bus(1'b0, 8'h59, 16'hFFFF, 4'hF);
    bus(1'b1, 8'h74, 16'h0000, 4'hF);
    chk("unmapped", 32'h0, q);
    bus(1'b1, 8'h5A, 16'h0000, 4'hF);
    chk("misaligned", 32'h0, q);
    allChk;
    $display("test unmapped done");
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rstModel;
    allChk;
    $display("test second reset done");
    wrap_up;
  end
endmodule
